// ---- src/shl_defines.svh ----
// Constants of the serial host link: register offsets, field positions,
// reset values, characters, flow thresholds and bit rates.
// Assumes a 25 MHz system clock unless the top parameter says otherwise.
`ifndef SHL_DEFINES_SVH
`define SHL_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SHL_REG_CTRL 5'h00
`define SHL_REG_ADDR 5'h04
`define SHL_REG_STATUS 5'h08
`define SHL_REG_TXDATA 5'h0c
`define SHL_REG_RXDATA 5'h10
`define SHL_REG_SLOT 5'h14

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define SHL_CTRL_WIDTH 11
`define SHL_CTRL_RESET 11'h250
`define SHL_BUS_ADDR_RESET 5'h05
`define SHL_BUS_ADDR_MAX 5'h1e
`define SHL_TX_EOR_BIT 8
`define SHL_SLOT_SAVE_BIT 2
`define SHL_STAT_CLR_LO 4
`define SHL_STAT_COUNT_LO 8

// ----------------------------------------------------------------------
// Characters
// ----------------------------------------------------------------------
`define SHL_CHAR_XOFF 8'h13
`define SHL_CHAR_XON 8'h11
`define SHL_CHAR_CR 8'h0d
`define SHL_CHAR_LF 8'h0a

// ----------------------------------------------------------------------
// Flow thresholds and timing
// ----------------------------------------------------------------------
`define SHL_RX_HOLD_FREE 16
`define SHL_RX_DEPTH 32
`define SHL_CLK_HZ 25000000
`define SHL_RATE_300 300
`define SHL_RATE_600 600
`define SHL_RATE_1200 1200
`define SHL_RATE_2400 2400
`define SHL_RATE_4800 4800
`define SHL_RATE_9600 9600

`endif

// ---- src/shl_pkg.sv ----
// Types of the serial host link: settings, bus request and state machines.
// Assumes shl_defines.svh supplies all numeric constants.
package shl_pkg;

  typedef enum logic [2:0] {
    SHL_PAR_NONE, SHL_PAR_EVEN, SHL_PAR_ODD, SHL_PAR_MARK, SHL_PAR_SPACE
  } shl_parity_type;

  typedef enum logic [2:0] {
    SHL_BAUD_300, SHL_BAUD_600, SHL_BAUD_1200, SHL_BAUD_2400, SHL_BAUD_4800,
    SHL_BAUD_9600
  } shl_baud_type;

  typedef enum logic [1:0] {
    SHL_FLOW_NONE, SHL_FLOW_SOFTWARE_HANDSHAKE, SHL_FLOW_RTS_CTS, SHL_FLOW_DTR_DSR
  } shl_flow_type;

  typedef struct packed {
    logic power_on_state_select;
    logic lang_scpi;
    shl_flow_type flow;
    shl_baud_type baud;
    shl_parity_type parity;
    logic host_port_select;
  } shl_settings_type;

  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } shl_avs_req_type;

  typedef enum logic [1:0] {SHL_RX_IDLE, SHL_RX_START, SHL_RX_DATA, SHL_RX_STOP} shl_rx_type;
  typedef enum logic {SHL_TX_IDLE, SHL_TX_SHIFT} shl_tx_type;

  typedef struct packed {
    shl_settings_type cfg;
    logic [4:0] addr;
    shl_settings_type [3:0] slot;
  } shl_nv_type;

endpackage : shl_pkg

// ---- src/shl_top.sv ----
// Serial host link of a bench instrument: host port selection, DTE serial
// port with framing, parity, bit rate and hold-off, and settings storage.
// Assumes one clock, registers reached over Avalon-MM and front-panel
// logic on the same clock that drives the bus address.
//
// Overview of operation
// - Factory bus address is 5.
// - Bus address accepted only from 0 to 30, kept in storage.
// - Bus address changes only from front panel, never over registers.
// - Serial port selected disables parallel bus and remote panel.
// - Port behaves as terminal equipment: drives TXD, RTS, DTR.
// - Every frame has ten bits: one start, eight payload, one stop.
// - Even or odd parity: seven data bits plus parity bit.
// - Mark parity bit always one, space parity bit always zero.
// - No parity: eight data bits, no parity bit.
// - Parity choice kept in storage.
// - Bit rate only 300 to 9600 in six steps, kept in storage.
// - At most five characters sent after host hold-off.
// - Receiver accepts sixteen more characters after raising hold-off.
// - Software handshake: code 19 holds off, code 17 releases.
// - RTS mode: RTS raised near full, CTS is host hold-off.
// - DTR mode: DTR raised near full, DSR is host hold-off.
// - No flow mode: no hold-off made or obeyed; choice stored.
// - Four storage slots 0 to 3 hold all settings, save and recall.
// - Save and recall only with standard command language.
// - Power-on choice: last stored settings or restore slot 0.
// - Each response ends with carriage return then newline.
// - Newline character is 0a.
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ps
`include "shl_defines.svh"

module shl_top
  import shl_pkg::*;
#(
  parameter int CLK_HZ = `SHL_CLK_HZ,
  parameter int RX_DEPTH = `SHL_RX_DEPTH
) (
  // Clock, resets and enable
  input wire logic CLK,
  input wire logic RESET,
  input wire logic NV_RESET,
  input wire logic CE,
  // Avalon-MM slave
  input wire shl_avs_req_type AVS_REQ,
  output logic AVS_WAITREQUEST,
  output logic [31:0] AVS_READDATA,
  // Serial pins, terminal-equipment side
  input wire logic RXD,
  input wire logic CTS,
  input wire logic DSR,
  output logic TXD,
  output logic RTS,
  output logic DTR,
  // Front panel address entry
  input wire logic PANEL_ADDR_WE,
  input wire logic [4:0] PANEL_ADDR,
  // Host port selection
  output logic PARALLEL_BUS_EN,
  output logic REMOTE_PANEL_EN,
  output logic [4:0] BUS_ADDRESS
);

  localparam int AW = $clog2(RX_DEPTH);
  localparam logic [8:0] HOLD_ON = 9'(RX_DEPTH - `SHL_RX_HOLD_FREE);
  localparam logic [8:0] HOLD_OFF = 9'(RX_DEPTH / 4);

  typedef struct packed {
    shl_settings_type set;
    logic [4:0] bus_addr;
    logic pon_pending;
    logic wait_r;
    logic [31:0] rdata;
    shl_tx_type tx_st;
    logic [9:0] tx_shift;
    logic [3:0] tx_bits;
    logic [16:0] tx_cnt;
    logic [7:0] tx_hold;
    logic tx_hold_v;
    logic tx_hold_eor;
    logic [1:0] tx_tail;
    logic dev_hold;
    logic sw_sent;
    logic sw_host_hold;
    shl_rx_type rx_st;
    logic [16:0] rx_cnt;
    logic [2:0] rx_bits;
    logic [7:0] rx_shift;
    logic [2:0] rxd_s;
    logic [2:0] cts_s;
    logic [2:0] dsr_s;
    logic rxd_f;
    logic cts_f;
    logic dsr_f;
    logic [7:0] wp;
    logic [7:0] rp;
    logic [8:0] count;
    logic par_err;
    logic frm_err;
    logic ovf;
    logic refused;
    logic txd;
    logic rts;
    logic dtr;
    logic par_en;
    logic pnl_en;
  } shl_state_type;

  shl_state_type q, d;
  shl_nv_type nv_q, nv_d;
  logic [7:0] rx_mem [RX_DEPTH];
  logic push;
  logic pop;
  logic [7:0] push_byte;
  logic [16:0] div;
  logic host_hold;
  logic [31:0] rd;
  logic [7:0] tx_char;
  logic tx_go;
  logic par_set;
  logic frm_set;
  logic ovf_set;
  logic ref_set;
  logic [3:0] clr;
  logic [7:0] rx_char;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Rounding down keeps the bit slightly short, well inside receiver margin.
  function automatic logic [16:0] bit_div(shl_baud_type b);
    int rate;
    unique case (b)
      SHL_BAUD_300: rate = `SHL_RATE_300;
      SHL_BAUD_600: rate = `SHL_RATE_600;
      SHL_BAUD_1200: rate = `SHL_RATE_1200;
      SHL_BAUD_2400: rate = `SHL_RATE_2400;
      SHL_BAUD_4800: rate = `SHL_RATE_4800;
      default: rate = `SHL_RATE_9600;
    endcase
    return 17'(CLK_HZ / rate);
  endfunction : bit_div

  function automatic logic [7:0] payload(shl_parity_type p, logic [7:0] c);
    logic [7:0] r;
    r = {1'b0, c[6:0]};
    unique case (p)
      SHL_PAR_EVEN: r[7] = ^c[6:0];
      SHL_PAR_ODD: r[7] = ~^c[6:0];
      SHL_PAR_MARK: r[7] = 1'b1;
      SHL_PAR_SPACE: r[7] = 1'b0;
      default: r = c;
    endcase
    return r;
  endfunction : payload

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d = q;
    nv_d = nv_q;
    push = 1'b0;
    pop = 1'b0;
    push_byte = 8'h00;
    par_set = 1'b0;
    frm_set = 1'b0;
    ovf_set = 1'b0;
    ref_set = 1'b0;
    clr = 4'h0;
    tx_go = 1'b0;
    tx_char = 8'h00;
    div = bit_div(q.set.baud);
    rx_char = (q.set.parity == SHL_PAR_NONE) ? q.rx_shift : {1'b0, q.rx_shift[6:0]};

    // Three-stage pin synchronisers; a change counts once stages two and three agree.
    d.rxd_s = {q.rxd_s[1:0], RXD};
    d.cts_s = {q.cts_s[1:0], CTS};
    d.dsr_s = {q.dsr_s[1:0], DSR};
    if (q.rxd_s[1] == q.rxd_s[2]) begin
      d.rxd_f = q.rxd_s[2];
    end
    if (q.cts_s[1] == q.cts_s[2]) begin
      d.cts_f = q.cts_s[2];
    end
    if (q.dsr_s[1] == q.dsr_s[2]) begin
      d.dsr_f = q.dsr_s[2];
    end

    unique case (q.set.flow)
      SHL_FLOW_SOFTWARE_HANDSHAKE: host_hold = q.sw_host_hold;
      SHL_FLOW_RTS_CTS: host_hold = q.cts_f;
      SHL_FLOW_DTR_DSR: host_hold = q.dsr_f;
      default: host_hold = 1'b0;
    endcase

    // Power-on load from storage, once after reset.
    if (q.pon_pending) begin
      d.pon_pending = 1'b0;
      d.bus_addr = nv_q.addr;
      d.set = nv_q.cfg;
      if (nv_q.cfg.power_on_state_select) begin
        d.set = nv_q.slot[0];
        d.set.power_on_state_select = 1'b1;
      end
    end else begin
      nv_d.cfg = q.set;
      nv_d.addr = q.bus_addr;
    end

    if (PANEL_ADDR_WE && PANEL_ADDR <= `SHL_BUS_ADDR_MAX) begin
      d.bus_addr = PANEL_ADDR;
    end

    // ----------------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------------
    unique case (q.rx_st)
      SHL_RX_IDLE: begin
        if (!q.rxd_f) begin
          d.rx_st = SHL_RX_START;
          d.rx_cnt = div >> 1;
        end
      end
      SHL_RX_START: begin
        if (q.rx_cnt != 17'h00000) begin
          d.rx_cnt = q.rx_cnt - 17'h00001;
        end else if (!q.rxd_f) begin
          d.rx_st = SHL_RX_DATA;
          d.rx_cnt = div - 17'h00001;
          d.rx_bits = 3'h0;
        end else begin
          d.rx_st = SHL_RX_IDLE;
        end
      end
      SHL_RX_DATA: begin
        if (q.rx_cnt != 17'h00000) begin
          d.rx_cnt = q.rx_cnt - 17'h00001;
        end else begin
          d.rx_shift = {q.rxd_f, q.rx_shift[7:1]};
          d.rx_cnt = div - 17'h00001;
          d.rx_bits = q.rx_bits + 3'h1;
          if (q.rx_bits == 3'h7) begin
            d.rx_st = SHL_RX_STOP;
          end
        end
      end
      SHL_RX_STOP: begin
        if (q.rx_cnt != 17'h00000) begin
          d.rx_cnt = q.rx_cnt - 17'h00001;
        end else begin
          d.rx_st = SHL_RX_IDLE;
          if (!q.rxd_f) begin
            frm_set = 1'b1;
          end else begin
            par_set = payload(q.set.parity, rx_char) != q.rx_shift;
            if (q.set.flow == SHL_FLOW_SOFTWARE_HANDSHAKE && rx_char == `SHL_CHAR_XOFF) begin
              d.sw_host_hold = 1'b1;
            end else if (q.set.flow == SHL_FLOW_SOFTWARE_HANDSHAKE &&
                         rx_char == `SHL_CHAR_XON) begin
              d.sw_host_hold = 1'b0;
            end else if (q.count == 9'(RX_DEPTH)) begin
              ovf_set = 1'b1;
            end else begin
              push = 1'b1;
              push_byte = rx_char;
            end
          end
        end
      end
    endcase
    if (q.set.flow != SHL_FLOW_SOFTWARE_HANDSHAKE) begin
      d.sw_host_hold = 1'b0;
      d.sw_sent = 1'b0;
    end

    // ----------------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------------
    unique case (AVS_REQ.address)
      `SHL_REG_CTRL: rd = 32'({q.set});
      `SHL_REG_ADDR: rd = 32'(q.bus_addr);
      `SHL_REG_STATUS: rd = {15'h0000, q.count, q.refused, q.ovf, q.frm_err, q.par_err,
                             q.count != 9'h000,
                             q.tx_st != SHL_TX_IDLE || q.tx_hold_v || q.tx_tail != 2'h0,
                             q.dev_hold, host_hold};
      `SHL_REG_RXDATA: rd = {23'h000000, q.count != 9'h000, rx_mem[q.rp[AW-1:0]]};
      default: rd = 32'h00000000;
    endcase

    if (!q.wait_r) begin
      // The master samples the answer at this edge; side effects happen here.
      d.wait_r = 1'b1;
      if (AVS_REQ.write) begin
        unique case (AVS_REQ.address)
          `SHL_REG_CTRL: begin
            d.set.host_port_select = AVS_REQ.writedata[0];
            if (AVS_REQ.writedata[3:1] <= 3'(SHL_PAR_SPACE)) begin
              d.set.parity = shl_parity_type'(AVS_REQ.writedata[3:1]);
            end
            if (AVS_REQ.writedata[6:4] <= 3'(SHL_BAUD_9600)) begin
              d.set.baud = shl_baud_type'(AVS_REQ.writedata[6:4]);
            end
            d.set.flow = shl_flow_type'(AVS_REQ.writedata[8:7]);
            d.set.lang_scpi = AVS_REQ.writedata[9];
            d.set.power_on_state_select = AVS_REQ.writedata[10];
          end
          `SHL_REG_STATUS: clr = AVS_REQ.writedata[`SHL_STAT_CLR_LO +: 4];
          `SHL_REG_TXDATA: begin
            d.tx_hold = AVS_REQ.writedata[7:0];
            d.tx_hold_eor = AVS_REQ.writedata[`SHL_TX_EOR_BIT];
            d.tx_hold_v = 1'b1;
          end
          `SHL_REG_SLOT: begin
            if (!q.set.lang_scpi) begin
              ref_set = 1'b1;
            end else if (AVS_REQ.writedata[`SHL_SLOT_SAVE_BIT]) begin
              nv_d.slot[AVS_REQ.writedata[1:0]] = q.set;
            end else begin
              d.set = nv_q.slot[AVS_REQ.writedata[1:0]];
              d.set.power_on_state_select = q.set.power_on_state_select;
            end
          end
          default: ; // Address register and unmapped words ignore writes.
        endcase
      end else if (AVS_REQ.read && AVS_REQ.address == `SHL_REG_RXDATA) begin
        // Pop only a char that was handed over; one landing after capture stays.
        pop = q.rdata[8];
      end
    end else if (AVS_REQ.read || AVS_REQ.write) begin
      // A transmit write stalls while the holding register is full.
      if (!(AVS_REQ.write && AVS_REQ.address == `SHL_REG_TXDATA && q.tx_hold_v)) begin
        d.wait_r = 1'b0;
        d.rdata = AVS_REQ.read ? rd : 32'h00000000;
      end
    end

    // ----------------------------------------------------------------------
    // Buffer and receive hold-off
    // ----------------------------------------------------------------------
    if (push) begin
      d.wp = q.wp + 8'h01;
    end
    if (pop) begin
      d.rp = q.rp + 8'h01;
    end
    d.count = q.count + 9'(push) - 9'(pop);
    // Raising at the sixteen-free mark leaves room for sixteen more characters.
    if (d.count >= HOLD_ON && q.set.flow != SHL_FLOW_NONE) begin
      d.dev_hold = 1'b1;
    end else if (d.count <= HOLD_OFF || q.set.flow == SHL_FLOW_NONE) begin
      d.dev_hold = 1'b0;
    end

    // Flags: a hardware set in the same cycle as a clear wins.
    d.par_err = (q.par_err & ~clr[0]) | par_set;
    d.frm_err = (q.frm_err & ~clr[1]) | frm_set;
    d.ovf = (q.ovf & ~clr[2]) | ovf_set;
    d.refused = (q.refused & ~clr[3]) | ref_set;

    // ----------------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------------
    unique case (q.tx_st)
      SHL_TX_IDLE: begin
        if (q.set.flow == SHL_FLOW_SOFTWARE_HANDSHAKE && q.dev_hold != q.sw_sent) begin
          tx_go = 1'b1;
          tx_char = q.dev_hold ? `SHL_CHAR_XOFF : `SHL_CHAR_XON;
          d.sw_sent = q.dev_hold;
        end else if (!host_hold) begin
          // Hold-off is checked before every start except XON and XOFF, so at most one more data frame goes.
          if (q.tx_tail == 2'h1) begin
            tx_go = 1'b1;
            tx_char = `SHL_CHAR_CR;
            d.tx_tail = 2'h2;
          end else if (q.tx_tail == 2'h2) begin
            tx_go = 1'b1;
            tx_char = `SHL_CHAR_LF;
            d.tx_tail = 2'h0;
          end else if (q.tx_hold_v) begin
            tx_go = 1'b1;
            tx_char = q.tx_hold;
            d.tx_hold_v = 1'b0;
            d.tx_tail = q.tx_hold_eor ? 2'h1 : 2'h0;
          end
        end
        if (tx_go) begin
          d.tx_shift = {1'b1, payload(q.set.parity, tx_char), 1'b0};
          d.tx_bits = 4'h0;
          d.tx_cnt = div - 17'h00001;
          d.tx_st = SHL_TX_SHIFT;
          d.txd = 1'b0;
        end
      end
      SHL_TX_SHIFT: begin
        if (q.tx_cnt != 17'h00000) begin
          d.tx_cnt = q.tx_cnt - 17'h00001;
        end else if (q.tx_bits == 4'h9) begin
          d.tx_st = SHL_TX_IDLE;
        end else begin
          d.tx_shift = {1'b1, q.tx_shift[9:1]};
          d.txd = q.tx_shift[1];
          d.tx_bits = q.tx_bits + 4'h1;
          d.tx_cnt = div - 17'h00001;
        end
      end
    endcase

    // ----------------------------------------------------------------------
    // Pin outputs
    // ----------------------------------------------------------------------
    d.rts = d.dev_hold && q.set.flow == SHL_FLOW_RTS_CTS;
    d.dtr = d.dev_hold && q.set.flow == SHL_FLOW_DTR_DSR;
    d.par_en = !q.set.host_port_select;
    d.pnl_en = !q.set.host_port_select;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      q <= '0;
      q.set <= shl_settings_type'(`SHL_CTRL_RESET);
      q.bus_addr <= `SHL_BUS_ADDR_RESET;
      q.pon_pending <= 1'b1;
      q.wait_r <= 1'b1;
      q.rxd_s <= 3'h7;
      q.cts_s <= 3'h0;
      q.dsr_s <= 3'h0;
      q.rxd_f <= 1'b1;
      q.txd <= 1'b1;
      q.tx_shift <= 10'h3ff;
      q.par_en <= 1'b1;
      q.pnl_en <= 1'b1;
    end else if (CE) begin
      q <= d;
    end
  end

  // Storage survives the power-on reset; only the factory clear reloads its factory values.
  always_ff @(posedge CLK or posedge NV_RESET) begin
    if (NV_RESET) begin
      nv_q.cfg <= shl_settings_type'(`SHL_CTRL_RESET);
      nv_q.addr <= `SHL_BUS_ADDR_RESET;
      nv_q.slot <= {4{shl_settings_type'(`SHL_CTRL_RESET)}};
    end else if (CE && !RESET) begin
      nv_q <= nv_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (CE && !RESET && push) begin
      rx_mem[q.wp[AW-1:0]] <= push_byte;
    end
  end

  assign AVS_WAITREQUEST = q.wait_r;
  assign AVS_READDATA = q.rdata;
  assign TXD = q.txd;
  assign RTS = q.rts;
  assign DTR = q.dtr;
  assign PARALLEL_BUS_EN = q.par_en;
  assign REMOTE_PANEL_EN = q.pnl_en;
  assign BUS_ADDRESS = q.bus_addr;

endmodule : shl_top

// ---- tb/shl_monitor.sv ----
// Checker of the serial host link top, bound to its ports.
// Assumes one clock and CE held high.
`timescale 1ns/1ps
module shl_monitor
  import shl_pkg::*;
#(
  parameter int CLK_HZ = 25000000
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Register bus
  input wire shl_avs_req_type AVS_REQ,
  input wire logic AVS_WAITREQUEST,
  // Serial pins and port selection
  input wire logic TXD,
  input wire logic RTS,
  input wire logic DTR,
  input wire logic PANEL_ADDR_WE,
  input wire logic PARALLEL_BUS_EN,
  input wire logic REMOTE_PANEL_EN,
  input wire logic [4:0] BUS_ADDRESS
);
  // No run on the wire may be shorter than one bit at the fastest rate.
  localparam int MIN_BIT = CLK_HZ / 9600;
  logic prev_q;
  logic [15:0] run_q;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      prev_q <= 1'b1;
      run_q <= 16'(MIN_BIT);
    end else begin
      prev_q <= TXD;
      run_q <= (TXD != prev_q) ? 16'h0001 : (&run_q ? run_q : run_q + 16'h0001);
    end
  end
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_ask; $rose(AVS_REQ.read); endsequence
  sequence s_ans; !AVS_WAITREQUEST ##1 AVS_WAITREQUEST; endsequence
  chk_reset_state: assert property (disable iff (1'b0) RESET |->
    BUS_ADDRESS == 5'h05 && TXD && !RTS && !DTR) else $error("outputs wrong in reset");
  chk_addr_range: assert property (BUS_ADDRESS <= 5'h1e)
    else $error("bus address above limit");
  chk_addr_panel: assert property (!$past(RESET) && !$past(RESET, 2) && !$past(RESET, 3)
    && $changed(BUS_ADDRESS) |-> $past(PANEL_ADDR_WE) || $past(PANEL_ADDR_WE, 2)
    || $past(PANEL_ADDR_WE, 3)) else $error("bus address changed without panel");
  chk_port_pair: assert property (PARALLEL_BUS_EN == REMOTE_PANEL_EN)
    else $error("port enables disagree");
  chk_bit_len: assert property (TXD != prev_q |-> run_q >= 16'(MIN_BIT))
    else $error("serial bit too short");
  chk_flow_excl: assert property (!(RTS && DTR))
    else $error("both hold-off lines raised");
  chk_read_answer: assert property (s_ask |=> s_ans)
    else $error("read not answered in time");
  chk_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
endmodule : shl_monitor

bind shl_top shl_monitor #(.CLK_HZ(CLK_HZ)) u_mon (.CLK(CLK), .RESET(RESET), .AVS_REQ(AVS_REQ),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .TXD(TXD), .RTS(RTS), .DTR(DTR),
  .PANEL_ADDR_WE(PANEL_ADDR_WE), .PARALLEL_BUS_EN(PARALLEL_BUS_EN),
  .REMOTE_PANEL_EN(REMOTE_PANEL_EN), .BUS_ADDRESS(BUS_ADDRESS));

// ---- tb/shl_host_model.sv ----
// Host serial port at the far end of a null-modem link.
// Assumes the bench sets bitc to the device bit time before traffic.
`timescale 1ns/1ps
module shl_host_model (
  // Clock and data lines
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  // Host hold-off lines, high holds the device off
  output logic cts,
  output logic dsr
);
  int bitc = 10;
  logic [7:0] rxq[$];
  logic [7:0] sh;
  initial begin
    rxd = 1'b1;
    cts = 1'b0;
    dsr = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bitc) @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask : send
  // A bad stop bit stores an unknown byte so that any compare fails.
  always begin
    @(negedge txd);
    repeat (bitc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitc) @(posedge clk);
      sh = {txd, sh[7:1]};
    end
    repeat (bitc) @(posedge clk);
    rxq.push_back(txd ? sh : 8'hxx);
  end
endmodule : shl_host_model

// ---- tb/tb.sv ----
// Self-checking bench of the serial host link against a host port model.
// Assumes the design package and defines are compiled first.
`timescale 1ns/1ps
module tb;
  import shl_pkg::*;
  localparam int HZ = 96000;
  localparam int RATE[6] = '{300, 600, 1200, 2400, 4800, 9600};
  logic CLK = 1'b0, RESET = 1'b0, NV_RESET = 1'b0, PANEL_ADDR_WE = 1'b0;
  logic [4:0] PANEL_ADDR = 5'h00;
  shl_avs_req_type req = '0;
  logic AVS_WAITREQUEST, TXD, RTS, DTR, PARALLEL_BUS_EN, REMOTE_PANEL_EN, RXD, CTS, DSR;
  logic [31:0] AVS_READDATA, rq, x;
  logic [4:0] BUS_ADDRESS;
  int bad_count = 0, total_checks = 0;
  always #20 CLK = ~CLK;
  shl_top #(.CLK_HZ(HZ)) u_dut (.CLK(CLK), .RESET(RESET), .NV_RESET(NV_RESET), .CE(1'b1),
    .AVS_REQ(req), .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_READDATA(AVS_READDATA),
    .RXD(RXD), .CTS(CTS), .DSR(DSR), .TXD(TXD), .RTS(RTS), .DTR(DTR),
    .PANEL_ADDR_WE(PANEL_ADDR_WE), .PANEL_ADDR(PANEL_ADDR), .PARALLEL_BUS_EN(PARALLEL_BUS_EN),
    .REMOTE_PANEL_EN(REMOTE_PANEL_EN), .BUS_ADDRESS(BUS_ADDRESS));
  shl_host_model host (.clk(CLK), .txd(TXD), .rxd(RXD), .cts(CTS), .dsr(DSR));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Waitrequest and read data are taken at the same rising edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    req <= '{address: a, read: !w, write: w, writedata: d};
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    rq = AVS_READDATA;
    req <= '0;
    @(posedge CLK);
  endtask : bus
  task automatic look;
    repeat (2) @(posedge CLK);
    @(negedge CLK);
  endtask : look
  task automatic wait_rx(input int n);
    for (int i = 0; i < 8000 && host.rxq.size() < n; i++) @(posedge CLK);
  endtask : wait_rx
  function automatic logic [31:0] cfg(input int p, input int b, input int f);
    return {21'h0, 1'b0, 1'b1, f[1:0], b[2:0], p[2:0], 1'b0};
  endfunction : cfg
  task automatic t_setup;
    @(negedge CLK);
    chk(BUS_ADDRESS, 5'h05);
    @(posedge CLK);
    bus(1'b0, 5'h00, 0);
    chk(rq, 32'h250);
    PANEL_ADDR <= 5'h1e;
    PANEL_ADDR_WE <= 1'b1;
    @(posedge CLK);
    PANEL_ADDR_WE <= 1'b0;
    @(posedge CLK);
    PANEL_ADDR <= 5'h1f;
    PANEL_ADDR_WE <= 1'b1;
    @(posedge CLK);
    PANEL_ADDR_WE <= 1'b0;
    bus(1'b1, 5'h04, 32'h7);
    bus(1'b0, 5'h04, 0);
    chk(rq[4:0], 5'h1e);
    bus(1'b1, 5'h00, 32'h251);
    look;
    chk({PARALLEL_BUS_EN, REMOTE_PANEL_EN, BUS_ADDRESS}, 7'h1e);
    @(posedge CLK);
    bus(1'b1, 5'h00, 32'h250);
    $display("setup test done");
  endtask : t_setup
  task automatic t_frame;
    logic [7:0] e;
    for (int p = 0; p < 5; p++) begin
      bus(1'b1, 5'h00, cfg(p, 5, 0));
      e = (p == 0) ? 8'hb5 : {(p == 1) ? ^7'h35 : (p == 2) ? ~^7'h35 : (p == 3), 7'h35};
      bus(1'b1, 5'h0c, 32'hb5);
      wait_rx(1);
      chk(host.rxq.pop_front(), e);
      host.send(e);
      bus(1'b0, 5'h10, 0);
      chk({rq[8], rq[7] & (p == 0), rq[6:0]}, {1'b1, e[7] & (p == 0), e[6:0]});
    end
    for (int b = 0; b < 6; b++) begin
      bus(1'b1, 5'h00, cfg(0, b, 0));
      host.bitc = HZ / RATE[b];
      bus(1'b1, 5'h0c, 32'h5a);
      wait_rx(1);
      chk(host.rxq.pop_front(), 8'h5a);
    end
    bus(1'b1, 5'h0c, 32'h141);
    wait_rx(3);
    chk({host.rxq[0], host.rxq[1], host.rxq[2]}, 24'h410d0a);
    host.rxq.delete();
    $display("frame test done");
  endtask : t_frame
  task automatic t_flow;
    for (int f = 1; f < 4; f++) begin
      bus(1'b1, 5'h00, cfg(0, 5, f));
      for (int i = 0; i < 31; i++) begin
        host.send(8'h40 + 8'(i));
        if (i == 15) begin
          if (f == 1) wait_rx(1);
          if (f == 1) chk(host.rxq.pop_front(), 8'h13);
          @(negedge CLK);
          chk({RTS, DTR}, (f == 2) ? 2'b10 : (f == 3) ? 2'b01 : 2'b00);
          @(posedge CLK);
        end
      end
      bus(1'b0, 5'h08, 0);
      chk({rq[16:8], rq[6]}, {9'h01f, 1'b0});
      for (int i = 0; i < 31; i++) begin
        bus(1'b0, 5'h10, 0);
        chk(rq[8:0], 9'h140 + 9'(i));
      end
      if (f == 1) wait_rx(1);
      if (f == 1) chk(host.rxq.pop_front(), 8'h11);
      look;
      chk({RTS, DTR}, 2'b00);
      @(posedge CLK);
      if (f == 1) host.send(8'h13);
      host.cts <= (f == 2);
      host.dsr <= (f == 3);
      repeat (4) @(posedge CLK);
      bus(1'b1, 5'h0c, 32'h21);
      repeat (300) @(posedge CLK);
      chk(host.rxq.size(), 0);
      if (f == 1) host.send(8'h11);
      host.cts <= 1'b0;
      host.dsr <= 1'b0;
      wait_rx(1);
      chk(host.rxq.pop_front(), 8'h21);
    end
    bus(1'b1, 5'h00, cfg(0, 5, 0));
    host.cts <= 1'b1;
    host.dsr <= 1'b1;
    bus(1'b1, 5'h0c, 32'h22);
    wait_rx(1);
    chk(host.rxq.pop_front(), 8'h22);
    host.cts <= 1'b0;
    host.dsr <= 1'b0;
    $display("flow test done");
  endtask : t_flow
  task automatic t_slot;
    x = cfg(1, 3, 2);
    bus(1'b1, 5'h00, x);
    bus(1'b1, 5'h14, 32'h6);
    bus(1'b1, 5'h00, 32'h250);
    bus(1'b1, 5'h14, 32'h2);
    bus(1'b0, 5'h00, 0);
    chk(rq, x);
    bus(1'b1, 5'h00, 32'h050);
    bus(1'b1, 5'h14, 32'h6);
    bus(1'b0, 5'h08, 0);
    chk(rq[7], 1'b1);
    bus(1'b1, 5'h08, 32'h80);
    bus(1'b1, 5'h00, x | 32'h400);
    bus(1'b1, 5'h14, 32'h4);
    bus(1'b1, 5'h00, 32'h650);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    repeat (3) @(posedge CLK);
    bus(1'b0, 5'h00, 0);
    chk({rq[9:0], 3'h0, BUS_ADDRESS}, {x[9:0], 8'h1e});
    $display("slot test done");
  endtask : t_slot
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    RESET <= 1'b1;
    NV_RESET <= 1'b1;
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    NV_RESET <= 1'b0;
    repeat (2) @(posedge CLK);
    t_setup;
    t_frame;
    t_flow;
    t_slot;
    final_report;
  end
  initial begin
    repeat (100000) @(posedge CLK);
    bad_count++;
    final_report;
  end
endmodule : tb
